// ### rtl/ombc_pkg.sv
package ombc_pkg;
  // Operating mode codes, as latched from the mode select pins
  localparam logic [2:0] MODE_SPC_SINGLE = 3'h0;
  localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPC_TEST = 3'h2;
  localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
  localparam logic [2:0] MODE_NRM_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NRM_NARROW = 3'h5;
  localparam logic [2:0] MODE_PERIPH = 3'h6;
  localparam logic [2:0] MODE_NRM_WIDE = 3'h7;
  localparam int MODE_W = 3;
  // Bit 2 clear marks the special modes
  localparam int MODE_NORMAL_BIT = 2;
  // Cycles after reset release before the synchronised pins are valid
  localparam logic [1:0] LATCH_DELAY = 2'h2;
  // Port E layout
  localparam int PE_W = 8;
  localparam int PE_CLK_BIT = 4;
  localparam logic [7:0] PE_PULL_SPC_SINGLE = 8'hEF;
  localparam logic [7:0] PE_PULL_OTHER = 8'h00;
  // Control bit reset values for single-chip and expanded modes
  localparam logic PE_ALT_RST_SINGLE = 1'b0;
  localparam logic PE_ALT_RST_EXP = 1'b1;
  localparam logic NO_CLK_RST_SPC_SINGLE = 1'b0;
  localparam logic NO_CLK_RST_NRM_SINGLE = 1'b1;
  localparam logic NO_CLK_RST_EXP = 1'b0;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_WAIT = 5'h01,
    ST_DEBUG = 5'h02,
    ST_VECTOR = 5'h04,
    ST_RUN = 5'h08,
    ST_PERIPH = 5'h10
  } ombc_state_t;
endpackage

// ### rtl/ombc_mode_if.sv
`timescale 1ns/1ps
interface ombc_mode_if;
  import ombc_pkg::*;
  logic [MODE_W-1:0] mode;
  logic valid;
  modport src (output mode, output valid);
  modport dst (input mode, input valid);
endinterface

// ### rtl/ombc_mode_latch.sv
`timescale 1ns/1ps
module ombc_mode_latch
  import ombc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Mode pins and mode bit writes
  input wire logic [MODE_W-1:0] mode_pins_i,
  input wire logic mode_wr_i,
  input wire logic [MODE_W-1:0] mode_wdata_i,
  // Latched mode
  ombc_mode_if.src mode_if
);
  logic [MODE_W-1:0] sync1_r, sync2_r, mode_r, mode_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic valid_r, valid_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    valid_nxt = valid_r;
    mode_nxt = mode_r;
    if (!valid_r) begin
      if (cnt_r == LATCH_DELAY) begin
        mode_nxt = sync2_r;
        valid_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end else if (mode_wr_i && !mode_r[MODE_NORMAL_BIT]) begin
      mode_nxt = mode_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      cnt_r <= 2'h0;
      valid_r <= 1'b0;
      mode_r <= 3'h0;
    end else begin
      sync1_r <= mode_pins_i;
      sync2_r <= sync1_r;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign mode_if.mode = mode_r;
  assign mode_if.valid = valid_r;

  AST_MODE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(valid_r) && $past(mode_r[MODE_NORMAL_BIT]) |-> $stable(mode_r))
    else $error("mode changed in normal mode");
endmodule // ombc_mode_latch

// ### rtl/ombc_chip_sel.sv
`timescale 1ns/1ps
module ombc_chip_sel
  import ombc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Mode and port K enable
  ombc_mode_if.dst mode_if,
  input wire logic emu_port_k_enable_i,
  // Current access
  input wire logic acc_valid_i,
  input wire logic acc_prog_mem_i,
  input wire logic acc_external_i,
  // Selects
  output logic emu_chip_select_n_o,
  output logic ext_chip_select_n_o
);
  logic emu_mode, emu_cs_act;
  logic emu_cs_n_r, emu_cs_n_nxt, ext_cs_n_r, ext_cs_n_nxt;

  always_comb begin
    emu_mode = mode_if.valid && (mode_if.mode == MODE_EMU_NARROW ||
      mode_if.mode == MODE_EMU_WIDE);
    emu_cs_act = emu_port_k_enable_i && emu_mode && acc_valid_i &&
      acc_prog_mem_i;
    emu_cs_n_nxt = !emu_cs_act;
    ext_cs_n_nxt = !(emu_port_k_enable_i && acc_valid_i && acc_external_i &&
      !emu_cs_act);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      emu_cs_n_r <= 1'b1;
      ext_cs_n_r <= 1'b1;
    end else begin
      emu_cs_n_r <= emu_cs_n_nxt;
      ext_cs_n_r <= ext_cs_n_nxt;
    end
  end

  assign emu_chip_select_n_o = emu_cs_n_r;
  assign ext_chip_select_n_o = ext_cs_n_r;

  AST_CS_EXCL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !(!emu_cs_n_r && !ext_cs_n_r))
    else $error("both chip selects active");
  AST_CS_PORTK_EN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !emu_port_k_enable_i ##1 !$past(emu_port_k_enable_i) |->
    emu_cs_n_r && ext_cs_n_r)
    else $error("chip select active with port K disabled");
endmodule // ombc_chip_sel

// ### rtl/ombc_top.sv
`timescale 1ns/1ps
module ombc_top
  import ombc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Mode pins and mode bit writes
  input wire logic [MODE_W-1:0] mode_pins_i,
  input wire logic mode_wr_i,
  input wire logic [MODE_W-1:0] mode_wdata_i,
  // Debug go command from the background debug pin logic
  input wire logic debug_go_i,
  // Control bit writes
  input wire logic cfg_wr_i,
  input wire logic pipe_status_out_en_i,
  input wire logic low_strobe_out_en_i,
  input wire logic rw_out_en_i,
  input wire logic bus_clock_out_disable_i,
  input wire logic emu_port_k_enable_i,
  // Current access
  input wire logic acc_valid_i,
  input wire logic acc_prog_mem_i,
  input wire logic acc_external_i,
  // Core control
  output logic background_debug_state_o,
  output logic cpu_active_o,
  output logic fetch_vector_o,
  output logic tester_master_o,
  output logic mode_reg_access_o,
  output logic [MODE_W-1:0] mode_o,
  // Port A and B usage
  output logic ab_ext_bus_o,
  output logic ab_wide_bus_o,
  output logic ab_pull_en_o,
  output logic ab_regs_external_o,
  // Port E usage
  output logic [PE_W-1:0] pe_pull_en_o,
  output logic pipe_status_hi_en_o,
  output logic pipe_status_lo_en_o,
  output logic low_byte_strobe_en_o,
  output logic rw_en_o,
  output logic port_e4_clk_en_o,
  output logic port_e4_bus_clock_out_o,
  // Stored control bits, readback
  output logic [4:0] cfg_bits_o,
  // Port K selects
  output logic emu_chip_select_n_o,
  output logic ext_chip_select_n_o
);
  ombc_mode_if mif ();
  ombc_state_t st_r, st_nxt;
  logic pipe_r, pipe_nxt, lstr_r, lstr_nxt, rw_r, rw_nxt;
  logic noclk_r, noclk_nxt, portk_en_r, portk_en_nxt, wrdone_r, wrdone_nxt;
  logic [MODE_W-1:0] mode;
  logic single, spc_single, expanded, periph, wr_ok, latch_now;
  logic valid_q_r;
  logic dbg_nxt, run_nxt, fetch_nxt, tester_nxt, macc_nxt;
  logic ext_nxt, wide_nxt, abpull_nxt, pe4en_nxt, bclk_nxt;
  logic pipeo_nxt, lstro_nxt, rwo_nxt;
  logic [PE_W-1:0] pepull_nxt;
  logic dbg_r, run_r, fetch_r, tester_r, macc_r, ext_r, wide_r;
  logic abpull_r, pe4en_r, bclk_r, pipeo_r, lstro_r, rwo_r;
  logic [PE_W-1:0] pepull_r;

  ombc_mode_latch u_latch (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .mode_pins_i(mode_pins_i),
    // no mode writes in peripheral mode
    .mode_wr_i(mode_wr_i && !periph),
    .mode_wdata_i(mode_wdata_i),
    .mode_if(mif.src)
  );

  ombc_chip_sel u_cs (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .mode_if(mif.dst),
    .emu_port_k_enable_i(portk_en_r),
    .acc_valid_i(acc_valid_i),
    .acc_prog_mem_i(acc_prog_mem_i),
    .acc_external_i(acc_external_i),
    .emu_chip_select_n_o(emu_chip_select_n_o),
    .ext_chip_select_n_o(ext_chip_select_n_o)
  );

  // Mode decode
  always_comb begin
    mode = mif.mode;
    single = mode == MODE_SPC_SINGLE || mode == MODE_NRM_SINGLE;
    spc_single = mode == MODE_SPC_SINGLE;
    periph = mif.valid && mode == MODE_PERIPH;
    expanded = !single && mode != MODE_PERIPH;
    latch_now = mif.valid && !valid_q_r;
  end

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_WAIT: begin
        if (mif.valid) begin
          if (spc_single) begin
            st_nxt = ST_DEBUG;
          end else if (mode == MODE_PERIPH) begin
            st_nxt = ST_PERIPH;
          end else begin
            st_nxt = ST_VECTOR;
          end
        end
      end
      ST_DEBUG: begin
        if (debug_go_i) begin
          st_nxt = ST_RUN;
        end
      end
      ST_VECTOR: st_nxt = ST_RUN;
      ST_RUN: st_nxt = ST_RUN;
      ST_PERIPH: st_nxt = ST_PERIPH;
      default: st_nxt = ST_WAIT;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ST_WAIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Control bits
  always_comb begin
    pipe_nxt = pipe_r;
    lstr_nxt = lstr_r;
    rw_nxt = rw_r;
    noclk_nxt = noclk_r;
    portk_en_nxt = portk_en_r;
    wrdone_nxt = wrdone_r;
    wr_ok = mif.valid && !periph &&
      (mode == MODE_SPC_TEST || !mode[MODE_NORMAL_BIT] || !wrdone_r);
    if (latch_now) begin
      // alternate enables reset to 0 in single chip
      pipe_nxt = single ? PE_ALT_RST_SINGLE : PE_ALT_RST_EXP;
      lstr_nxt = single ? PE_ALT_RST_SINGLE : PE_ALT_RST_EXP;
      rw_nxt = single ? PE_ALT_RST_SINGLE : PE_ALT_RST_EXP;
      // clock out in special single chip
      noclk_nxt = spc_single ? NO_CLK_RST_SPC_SINGLE :
        (single ? NO_CLK_RST_NRM_SINGLE : NO_CLK_RST_EXP);
    end else if (cfg_wr_i && wr_ok) begin
      pipe_nxt = pipe_status_out_en_i;
      lstr_nxt = low_strobe_out_en_i;
      rw_nxt = rw_out_en_i;
      noclk_nxt = bus_clock_out_disable_i;
      portk_en_nxt = emu_port_k_enable_i;
      wrdone_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pipe_r <= 1'b0;
      lstr_r <= 1'b0;
      rw_r <= 1'b0;
      noclk_r <= 1'b0;
      portk_en_r <= 1'b0;
      wrdone_r <= 1'b0;
      valid_q_r <= 1'b0;
    end else begin
      pipe_r <= pipe_nxt;
      lstr_r <= lstr_nxt;
      rw_r <= rw_nxt;
      noclk_r <= noclk_nxt;
      portk_en_r <= portk_en_nxt;
      wrdone_r <= wrdone_nxt;
      valid_q_r <= mif.valid;
    end
  end

  // Pin usage, registered so every output leaves a flip-flop
  always_comb begin
    dbg_nxt = st_nxt == ST_DEBUG;
    run_nxt = st_nxt == ST_RUN || st_nxt == ST_VECTOR;
    fetch_nxt = st_nxt == ST_VECTOR;
    tester_nxt = st_nxt == ST_PERIPH;
    macc_nxt = mif.valid && mode != MODE_PERIPH;
    ext_nxt = mif.valid && expanded;
    wide_nxt = mif.valid && (mode == MODE_EMU_WIDE ||
      mode == MODE_NRM_WIDE || mode == MODE_SPC_TEST ||
      mode == MODE_PERIPH);
    abpull_nxt = 1'b0;
    // port E pulls in special single chip
    pepull_nxt = (mif.valid && spc_single) ? PE_PULL_SPC_SINGLE :
      PE_PULL_OTHER;
    pipeo_nxt = mif.valid && !single && pipe_r;
    lstro_nxt = mif.valid && !single && lstr_r;
    rwo_nxt = mif.valid && !single && rw_r;
    // bus clock while disable bit clear, except in peripheral mode
    // Wait for the loaded disable bit, else one stray pulse leaves at latch
    pe4en_nxt = valid_q_r && !periph && !noclk_r;
    // Free-running clock at half the bus rate
    bclk_nxt = pe4en_nxt ? !bclk_r : 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dbg_r <= 1'b0;
      run_r <= 1'b0;
      fetch_r <= 1'b0;
      tester_r <= 1'b0;
      macc_r <= 1'b0;
      ext_r <= 1'b0;
      wide_r <= 1'b0;
      abpull_r <= 1'b0;
      pepull_r <= 8'h00;
      pipeo_r <= 1'b0;
      lstro_r <= 1'b0;
      rwo_r <= 1'b0;
      pe4en_r <= 1'b0;
      bclk_r <= 1'b0;
    end else begin
      dbg_r <= dbg_nxt;
      run_r <= run_nxt;
      fetch_r <= fetch_nxt;
      tester_r <= tester_nxt;
      macc_r <= macc_nxt;
      ext_r <= ext_nxt;
      wide_r <= wide_nxt;
      abpull_r <= abpull_nxt;
      pepull_r <= pepull_nxt;
      pipeo_r <= pipeo_nxt;
      lstro_r <= lstro_nxt;
      rwo_r <= rwo_nxt;
      pe4en_r <= pe4en_nxt;
      bclk_r <= bclk_nxt;
    end
  end

  assign background_debug_state_o = dbg_r;
  assign cpu_active_o = run_r;
  assign fetch_vector_o = fetch_r;
  assign tester_master_o = tester_r;
  assign mode_reg_access_o = macc_r;
  assign mode_o = mif.mode;
  assign ab_ext_bus_o = ext_r;
  assign ab_wide_bus_o = wide_r;
  assign ab_pull_en_o = abpull_r;
  assign ab_regs_external_o = ext_r;
  assign pe_pull_en_o = pepull_r;
  assign pipe_status_hi_en_o = pipeo_r;
  assign pipe_status_lo_en_o = pipeo_r;
  assign low_byte_strobe_en_o = lstro_r;
  assign rw_en_o = rwo_r;
  assign port_e4_clk_en_o = pe4en_r;
  assign port_e4_bus_clock_out_o = bclk_r;
  assign cfg_bits_o = {portk_en_r, noclk_r, rw_r, lstr_r, pipe_r};

  AST_DBG_NO_FETCH: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st_r == ST_DEBUG |-> !fetch_nxt && !run_nxt || debug_go_i)
    else $error("core runs during debug");
  AST_DBG_GO: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st_r == ST_DEBUG && debug_go_i |=> ##1 cpu_active_o && !fetch_vector_o)
    else $error("go command did not start core");
  AST_SINGLE_ALT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(mif.valid) && $past(single) |-> !pipe_status_hi_en_o &&
    !low_byte_strobe_en_o && !rw_en_o)
    else $error("alternate port E function in single chip");
  AST_SPC_PULL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(mif.valid) && $past(spc_single) |->
    pe_pull_en_o == PE_PULL_SPC_SINGLE && !ab_ext_bus_o && !ab_pull_en_o)
    else $error("wrong pin setup in special single chip");
  AST_BUS_CLK: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    port_e4_clk_en_o ##1 port_e4_clk_en_o |->
    port_e4_bus_clock_out_o != $past(port_e4_bus_clock_out_o))
    else $error("bus clock output not toggling");
  AST_PERIPH: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st_r == ST_PERIPH |=> tester_master_o && !cpu_active_o &&
    !mode_reg_access_o)
    else $error("peripheral mode core or mode access active");
  AST_EXP_BUS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(mif.valid) && $past(mode) == MODE_NRM_WIDE |->
    ab_ext_bus_o && ab_wide_bus_o && ab_regs_external_o)
    else $error("wide bus not enabled");
endmodule // ombc_top

// ### test/ombc_ext_master.sv
`timescale 1ns/1ps
module ombc_ext_master (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Requests from the bench
  input wire logic go_req_i,
  input wire logic [3:0] go_wait_i,
  input wire logic acc_req_i,
  input wire logic acc_prog_i,
  input wire logic acc_ext_i,
  // Lines into the device
  output logic debug_go_o,
  output logic acc_valid_o,
  output logic acc_prog_mem_o,
  output logic acc_external_o
);
  logic [3:0] wait_r;
  logic req_r;
  logic prog_r;
  logic ext_r;

  initial begin
    debug_go_o = 1'b0;
    acc_valid_o = 1'b0;
    acc_prog_mem_o = 1'b0;
    acc_external_o = 1'b0;
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= 4'h0;
    end else if (go_req_i) begin
      wait_r <= go_wait_i + 4'h1;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
    req_r <= acc_req_i;
    prog_r <= acc_prog_i;
    ext_r <= acc_ext_i;
  end

  // tester drives qualifiers
  // Idle qualifiers flip so a stale value never looks like a request
  always @(negedge clock_i) begin
    debug_go_o <= (wait_r == 4'h1);
    acc_valid_o <= req_r;
    acc_prog_mem_o <= req_r ? prog_r : ~acc_prog_mem_o;
    acc_external_o <= req_r ? ext_r : ~acc_external_o;
  end
endmodule // ombc_ext_master

// ### test/ombc_top_tb.sv
`timescale 1ns/1ps
module ombc_top_tb
  import ombc_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] mode_pins = 3'h0;
  logic mode_wr = 1'b0;
  logic [2:0] mode_wdata = 3'h0;
  logic cfg_wr = 1'b0;
  logic [4:0] cfg_v = 5'h00;
  logic go_req = 1'b0;
  logic [3:0] go_wait = 4'h0;
  logic acc_req = 1'b0;
  logic acc_prog = 1'b0;
  logic acc_ext = 1'b0;
  logic debug_go, acc_valid, acc_prog_mem, acc_external;
  logic dbg_st, cpu_act, fetch_vec, tester, mode_acc;
  logic [2:0] mode;
  logic ab_ext, ab_wide, ab_pull, ab_regs;
  logic [7:0] pe_pull;
  logic p_hi, p_lo, lo_strb, rw_en, e4_en, e4_clk;
  logic [4:0] cfg_bits;
  logic emu_cs_n, ext_cs_n;
  int num_errors = 0;
  int total_checks = 0;
  int fv_cnt = 0;

  always #4 clock_i = ~clock_i;

  ombc_ext_master partner (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .go_req_i(go_req), .go_wait_i(go_wait), .acc_req_i(acc_req),
    .acc_prog_i(acc_prog), .acc_ext_i(acc_ext), .debug_go_o(debug_go),
    .acc_valid_o(acc_valid), .acc_prog_mem_o(acc_prog_mem),
    .acc_external_o(acc_external));

  ombc_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .mode_pins_i(mode_pins), .mode_wr_i(mode_wr),
    .mode_wdata_i(mode_wdata), .debug_go_i(debug_go), .cfg_wr_i(cfg_wr),
    .pipe_status_out_en_i(cfg_v[0]), .low_strobe_out_en_i(cfg_v[1]),
    .rw_out_en_i(cfg_v[2]), .bus_clock_out_disable_i(cfg_v[3]),
    .emu_port_k_enable_i(cfg_v[4]), .acc_valid_i(acc_valid),
    .acc_prog_mem_i(acc_prog_mem), .acc_external_i(acc_external),
    .background_debug_state_o(dbg_st), .cpu_active_o(cpu_act),
    .fetch_vector_o(fetch_vec), .tester_master_o(tester),
    .mode_reg_access_o(mode_acc), .mode_o(mode), .ab_ext_bus_o(ab_ext),
    .ab_wide_bus_o(ab_wide), .ab_pull_en_o(ab_pull),
    .ab_regs_external_o(ab_regs), .pe_pull_en_o(pe_pull),
    .pipe_status_hi_en_o(p_hi), .pipe_status_lo_en_o(p_lo),
    .low_byte_strobe_en_o(lo_strb), .rw_en_o(rw_en),
    .port_e4_clk_en_o(e4_en), .port_e4_bus_clock_out_o(e4_clk),
    .cfg_bits_o(cfg_bits), .emu_chip_select_n_o(emu_cs_n),
    .ext_chip_select_n_o(ext_cs_n));

  always @(posedge clock_i) begin
    if (fetch_vec === 1'b1) begin
      fv_cnt <= fv_cnt + 1;
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(negedge clock_i);
    rst_b_i = 1'b0;
    mode_pins = m;
    repeat (10) @(negedge clock_i);
    chk({emu_cs_n, ext_cs_n, cpu_act}, 8'h06);
    rst_b_i = 1'b1;
    fv_cnt = 0;
    repeat (6) @(negedge clock_i);
  endtask

  // Pulse a control write, return once the pin enables have settled
  task automatic wr_cfg(input logic [4:0] v);
    @(negedge clock_i);
    cfg_v = v;
    cfg_wr = 1'b1;
    @(negedge clock_i);
    cfg_wr = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask

  task automatic wr_mode(input logic [2:0] m);
    @(negedge clock_i);
    mode_wdata = m;
    mode_wr = 1'b1;
    @(negedge clock_i);
    mode_wr = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask

  task automatic cs(input logic req, prog, ext, e_emu, e_ext);
    @(negedge clock_i);
    acc_req = req;
    acc_prog = prog;
    acc_ext = ext;
    repeat (3) @(negedge clock_i);
    chk({emu_cs_n, ext_cs_n}, {6'h00, e_emu, e_ext});
    acc_req = 1'b0;
  endtask

  task automatic t_spc_single();
    logic b;
    do_reset(MODE_SPC_SINGLE);
    chk({dbg_st, cpu_act}, 8'h02);
    chk({ab_ext, ab_pull}, 8'h00);
    chk(pe_pull, 8'hEF);
    chk(e4_en, 8'h01);
    b = e4_clk;
    @(negedge clock_i);
    chk(e4_clk, {7'h00, ~b});
    chk({3'h0, cfg_bits}, 8'h00);
    chk({4'h0, p_hi, p_lo, lo_strb, rw_en}, 8'h00);
    wr_cfg(5'h07);
    chk(cfg_bits, 8'h07);
    chk({p_hi, p_lo, lo_strb, rw_en}, 8'h00);
    chk(fv_cnt[7:0], 8'h00);
    // The debugger answers slowly: core stays held meanwhile
    @(negedge clock_i);
    go_wait = 4'h3;
    go_req = 1'b1;
    @(negedge clock_i);
    go_req = 1'b0;
    repeat (3) @(negedge clock_i);
    chk({dbg_st, cpu_act}, 8'h02);
    repeat (2) @(negedge clock_i);
    chk({dbg_st, cpu_act}, 8'h01);
    chk(cfg_bits, 8'h07);
    wr_mode(MODE_EMU_WIDE);
    chk(mode, 8'h03);
    chk({ab_ext, ab_wide, ab_regs}, 8'h07);
    chk({p_hi, p_lo, lo_strb, rw_en}, 8'h0F);
  endtask

  task automatic t_nrm_single();
    do_reset(MODE_NRM_SINGLE);
    chk({dbg_st, cpu_act}, 8'h01);
    chk(fv_cnt[7:0], 8'h01);
    chk({e4_en, e4_clk}, 8'h00);
    wr_cfg(5'h00);
    chk(e4_en, 8'h01);
    mode_pins = MODE_NRM_WIDE;
    wr_mode(MODE_SPC_SINGLE);
    chk(mode, {5'h00, MODE_NRM_SINGLE});
    chk({ab_ext, ab_wide}, 8'h00);
    wr_cfg(5'h08);
    chk({cfg_bits, e4_en}, 8'h01);
  endtask

  task automatic t_spc_test();
    logic [4:0] v[3] = '{5'h08, 5'h01, 5'h1E};
    do_reset(MODE_SPC_TEST);
    chk({ab_ext, ab_wide}, 8'h03);
    chk(pe_pull, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_cfg(v[i]);
      chk(cfg_bits, {3'h0, v[i]});
    end
    chk({p_hi, p_lo, lo_strb, rw_en, e4_en}, 8'h06);
  endtask

  task automatic t_expanded();
    do_reset(MODE_NRM_WIDE);
    chk({ab_ext, ab_wide, ab_regs}, 8'h07);
    chk({p_hi, p_lo, lo_strb, rw_en}, 8'h0F);
    chk({dbg_st, cpu_act, e4_en}, 8'h03);
    chk(fv_cnt[7:0], 8'h01);
    do_reset(MODE_NRM_NARROW);
    chk({ab_ext, ab_wide, ab_regs}, 8'h05);
  endtask

  task automatic t_periph();
    do_reset(MODE_PERIPH);
    chk({tester, cpu_act, dbg_st}, 8'h04);
    chk(fv_cnt[7:0], 8'h00);
    chk(mode_acc, 8'h00);
    wr_mode(MODE_SPC_SINGLE);
    chk(mode, {5'h00, MODE_PERIPH});
    wr_cfg(5'h10);
    cs(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_chip_sel();
    do_reset(MODE_EMU_WIDE);
    chk({mode_acc, mode}, 8'h0B);
    cs(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    wr_cfg(5'h10);
    cs(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    cs(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    cs(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    cs(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    cs(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    // Outside emulation the emulation select stays idle
    wr_mode(MODE_SPC_TEST);
    cs(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
  endtask

  initial begin
    t_spc_single();
    t_nrm_single();
    t_spc_test();
    t_expanded();
    t_periph();
    t_chip_sel();
    give_verdict();
  end

  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #50000;
    num_errors++;
    give_verdict();
  end
endmodule // ombc_top_tb
